// ==== inc/ubirq_map.svh ====
// Register offsets, field positions and reset values of the UART irq block
`ifndef UBIRQ_MAP_SVH
`define UBIRQ_MAP_SVH
`define UBIRQ_ADDR_W 32
`define UBIRQ_OFF_DATA 32'h4000_5000
`define UBIRQ_OFF_IEN 32'h4000_5004
`define UBIRQ_OFF_IIR 32'h4000_5008
`define UBIRQ_OFF_IMASK 32'h4000_5030
`define UBIRQ_OFF_ISTAT 32'h4000_5034
`define UBIRQ_OFF_EVT 32'h4000_5038
`define UBIRQ_RST_DATA 8'h00
`define UBIRQ_RST_IEN 8'h00
`define UBIRQ_RST_IIR 8'h01
`define UBIRQ_IEN_MASK 8'h3F
`define UBIRQ_BIT_RX_FULL 0
`define UBIRQ_BIT_TX_EMPTY 1
`define UBIRQ_BIT_LINE 2
`define UBIRQ_BIT_MODEM 3
`define UBIRQ_BIT_RX_DMA 4
`define UBIRQ_BIT_TX_DMA 5
`define UBIRQ_CODE_MODEM 2'h0
`define UBIRQ_CODE_TX_EMPTY 2'h1
`define UBIRQ_CODE_RX_FULL 2'h2
`define UBIRQ_CODE_LINE 2'h3
`endif

// ==== inc/ubirq_pkg.sv ====
// Types of the UART buffer/irq block
package ubirq_pkg;
    typedef logic [7:0] ubirq_byte_t;
    typedef logic [1:0] ubirq_code_t;
endpackage

// ==== rtl/ubirq_top.sv ====
// UART transmit/receive buffers, interrupt enable and identification logic
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ubirq_map.svh"

// Summary of operation
// - Write at data address loads 8-bit transmit byte, reset zero.
// - Read at data address returns last received byte, reset zero.
// - Enable bit 5 gates transmit DMA request.
// - Enable bit 4 gates receive DMA request.
// - Enable bit 3 raises modem interrupt while modem status bit 0 set.
// - Enable bit 2 raises line interrupt while line status bits 4:1 set.
// - Enable bit 1 raises transmit empty interrupt while holding empty.
// - Enabling transmit empty while already empty interrupts at once.
// - Enable bit 0 raises receive full interrupt on received byte load.
// - Enabling receive full while already full interrupts at once.
// - Identification bit 0 is one when nothing pending; resets 0x01.
// - Identification bits 2:1 encode cause: modem, tx, rx, line.
// - Reading receive buffer clears receive full condition.
// - Reading line status clears line status condition.
// - Priority: line status, receive full, transmit empty, modem.
// - Transmit empty clears on holding write or identification read.
// - The four causes share o_irq; identification tells the cause; masked events also raise o_evt_irq.
module ubirq_top (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_rx_load,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_tx_take,
    input wire logic i_line_err,
    input wire logic i_line_rd,
    input wire logic i_modem_stat,
    output logic [7:0] o_tx_byte,
    output logic o_tx_full,
    output logic o_irq,
    output logic o_tx_dma_req,
    output logic o_rx_dma_req,
    output logic o_evt_irq
);

    // ========================================================
    // Decode
    logic sel_data;
    logic sel_ien;
    logic sel_iir;
    logic sel_mask;
    logic sel_stat;
    logic sel_evt;
    assign sel_data = (i_addr == `UBIRQ_OFF_DATA);
    assign sel_ien = (i_addr == `UBIRQ_OFF_IEN);
    assign sel_iir = (i_addr == `UBIRQ_OFF_IIR);
    assign sel_mask = (i_addr == `UBIRQ_OFF_IMASK);
    assign sel_stat = (i_addr == `UBIRQ_OFF_ISTAT);
    assign sel_evt = (i_addr == `UBIRQ_OFF_EVT);

    // ========================================================
    // Buffers
    ubirq_pkg::ubirq_byte_t tx_r;
    ubirq_pkg::ubirq_byte_t rx_r;
    ubirq_pkg::ubirq_byte_t ien_r;
    logic tx_full_r;
    logic rx_full_r;
    logic tx_wr;
    logic rx_rd;
    assign tx_wr = i_wr && sel_data;
    assign rx_rd = i_rd && sel_data;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_r <= `UBIRQ_RST_DATA;
        end else if (tx_wr) begin
            tx_r <= i_wdata[7:0];
        end
    end

    // A write while still full overwrites the pending byte, as in software
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_full_r <= 1'b0;
        end else if (tx_wr) begin
            tx_full_r <= 1'b1;
        end else if (i_tx_take) begin
            tx_full_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_r <= `UBIRQ_RST_DATA;
        end else if (i_rx_load) begin
            rx_r <= i_rx_byte;
        end
    end

    a_rx_byte_load: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_rx_load |=> rx_r == $past(i_rx_byte))
        else $error("received byte not stored");

    // Load beats a same-cycle read so a new byte is never lost
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_full_r <= 1'b0;
        end else if (i_rx_load) begin
            rx_full_r <= 1'b1;
        end else if (rx_rd) begin
            rx_full_r <= 1'b0;
        end
    end

    a_rx_load_full: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_rx_load |=> rx_full_r)
        else $error("rx load did not set full");

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ien_r <= `UBIRQ_RST_IEN;
        end else if (i_wr && sel_ien) begin
            ien_r <= i_wdata[7:0] & `UBIRQ_IEN_MASK;
        end
    end

    // Enabling receive full over a full buffer must not wait for a load
    a_rx_full_arm: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_wr && sel_ien && i_wdata[`UBIRQ_BIT_RX_FULL] && rx_full_r
        |=> ##1 o_irq)
        else $error("rx full enable no irq");

    // ========================================================
    // Transmit empty condition
    // Armed at reset, when holding empties, and on a rising enable while empty; cleared by holding write or identification read
    logic tx_cond_r;
    logic tx_empty_evt;
    logic p_line;
    logic p_rx;
    logic p_tx;
    logic p_mdm;
    logic no_pend;
    ubirq_pkg::ubirq_code_t cur_code;
    assign tx_empty_evt = i_tx_take && !tx_wr;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_cond_r <= 1'b1;
        end else if (tx_empty_evt) begin
            tx_cond_r <= 1'b1;
        end else if (tx_wr || (i_rd && sel_iir && cur_code ==
                     `UBIRQ_CODE_TX_EMPTY && !no_pend)) begin
            tx_cond_r <= 1'b0;
        end else if (i_wr && sel_ien && i_wdata[`UBIRQ_BIT_TX_EMPTY]
                     && !ien_r[`UBIRQ_BIT_TX_EMPTY] && !tx_full_r) begin
            tx_cond_r <= 1'b1;
        end
    end

    a_tx_take_set: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        tx_empty_evt |=> tx_cond_r)
        else $error("tx empty not armed");
    a_iir_read_clr: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_rd && sel_iir && !no_pend && !tx_empty_evt
        && cur_code == `UBIRQ_CODE_TX_EMPTY |=> !tx_cond_r)
        else $error("identification read kept tx empty");
    a_tx_empty_arm: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_wr && sel_ien && i_wdata[`UBIRQ_BIT_TX_EMPTY]
        && !ien_r[`UBIRQ_BIT_TX_EMPTY] && !tx_full_r |=> ##1 o_irq)
        else $error("tx empty enable no irq");

    // Line condition: set by error, cleared by a line status read
    logic line_cond_r;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            line_cond_r <= 1'b0;
        end else if (i_line_err) begin
            line_cond_r <= 1'b1;
        end else if (i_line_rd) begin
            line_cond_r <= 1'b0;
        end
    end

    a_line_err_set: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_line_err |=> line_cond_r)
        else $error("line error not held");
    a_line_read_clr: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_line_rd && !i_line_err |=> !line_cond_r)
        else $error("line status read did not clear");

    // ========================================================
    // Prioritised cause
    assign p_line = ien_r[`UBIRQ_BIT_LINE] && line_cond_r;
    assign p_rx = ien_r[`UBIRQ_BIT_RX_FULL] && rx_full_r;
    assign p_tx = ien_r[`UBIRQ_BIT_TX_EMPTY] && tx_cond_r;
    assign p_mdm = ien_r[`UBIRQ_BIT_MODEM] && i_modem_stat;
    assign no_pend = !(p_line || p_rx || p_tx || p_mdm);

    always_comb begin
        if (p_line) begin
            cur_code = `UBIRQ_CODE_LINE;
        end else if (p_rx) begin
            cur_code = `UBIRQ_CODE_RX_FULL;
        end else if (p_tx) begin
            cur_code = `UBIRQ_CODE_TX_EMPTY;
        end else begin
            cur_code = `UBIRQ_CODE_MODEM;
        end
    end

    logic [7:0] iir_val;
    assign iir_val = {5'h00, (no_pend ? 2'h0 : cur_code), no_pend};

    a_rx_prio: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        p_rx && !p_line |-> iir_val[2:0] == 3'h4)
        else $error("receive full code wrong");
    a_tx_prio: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        p_tx && !p_line && !p_rx |-> iir_val[2:0] == 3'h2)
        else $error("transmit empty code wrong");
    a_modem_cause: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        ien_r[`UBIRQ_BIT_MODEM] && i_modem_stat |=> o_irq)
        else $error("modem status no irq");
    a_line_cause: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        ien_r[`UBIRQ_BIT_LINE] && line_cond_r |=> o_irq)
        else $error("line status no irq");
    a_iir_idle_code: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        no_pend |-> iir_val == `UBIRQ_RST_IIR)
        else $error("idle identification wrong");

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= !no_pend;
        end
    end

    // ========================================================
    // Event status and mask (sticky, write one to clear)
    logic [3:0] evt_r;
    logic [3:0] mask_r;
    logic [3:0] evt_set;
    assign evt_set = {i_modem_stat, i_line_err, tx_empty_evt, i_rx_load};
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            evt_r <= 4'h0;
        end else if (i_wr && sel_stat) begin
            evt_r <= (evt_r & ~i_wdata[3:0]) | evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mask_r <= 4'h0;
        end else if (i_wr && sel_mask) begin
            mask_r <= i_wdata[3:0];
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_evt_irq <= 1'b0;
        end else begin
            o_evt_irq <= |((evt_r | evt_set) & mask_r);
        end
    end

    // ========================================================
    // DMA and transmit outputs
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_tx_dma_req <= 1'b0;
            o_rx_dma_req <= 1'b0;
            o_tx_byte <= `UBIRQ_RST_DATA;
            o_tx_full <= 1'b0;
        end else begin
            o_tx_dma_req <= ien_r[`UBIRQ_BIT_TX_DMA] && !tx_full_r;
            o_rx_dma_req <= ien_r[`UBIRQ_BIT_RX_DMA] && rx_full_r;
            o_tx_byte <= tx_wr ? i_wdata[7:0] : tx_r;
            o_tx_full <= tx_wr || (tx_full_r && !i_tx_take);
        end
    end

    a_tx_full_set: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        tx_wr |=> o_tx_full && o_tx_byte == $past(i_wdata[7:0]))
        else $error("holding byte not shown");
    a_tx_dma_empty: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        ien_r[`UBIRQ_BIT_TX_DMA] && !tx_full_r |=> o_tx_dma_req)
        else $error("tx dma request missing");
    a_rx_dma_full: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        ien_r[`UBIRQ_BIT_RX_DMA] && rx_full_r |=> o_rx_dma_req)
        else $error("rx dma request missing");

    // ========================================================
    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (1'b1)
                sel_data: o_rdata <= {24'h00_0000, rx_r};
                sel_ien: o_rdata <= {24'h00_0000, ien_r};
                sel_iir: o_rdata <= {24'h00_0000, iir_val};
                sel_mask: o_rdata <= {28'h000_0000, mask_r};
                sel_stat: o_rdata <= {28'h000_0000, evt_r};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    a_rx_read_data: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        rx_rd |=> o_rdata == {24'h00_0000, $past(rx_r)})
        else $error("receive buffer read wrong");
    a_ien_read_resv: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_rd && sel_ien |=> o_rdata[31:8] == 24'h00_0000
        && o_rdata[7:6] == 2'h0)
        else $error("enable reserved bits not zero");

    // ========================================================
    // Checks
    a_iir_reset_idle: assert property (@(posedge i_mclk)
        !i_resetn |=> iir_val == `UBIRQ_RST_IIR)
        else $error("iir not idle after reset");
    a_irq_follows: assert property (@(posedge i_mclk)
        disable iff (!i_resetn) ##1 (o_irq == !$past(no_pend)))
        else $error("irq does not follow pending");
    a_line_prio: assert property (@(posedge i_mclk)
        disable iff (!i_resetn) p_line |-> iir_val[2:0] == 3'h6)
        else $error("line status not highest");
    a_rx_read_clr: assert property (@(posedge i_mclk)
        disable iff (!i_resetn) rx_rd && !i_rx_load |=> !rx_full_r)
        else $error("rx read did not clear");
    a_tx_wr_clr: assert property (@(posedge i_mclk)
        disable iff (!i_resetn) tx_wr && !i_tx_take |=> !tx_cond_r)
        else $error("tx write did not clear");
    a_tx_dma_gate: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        !$past(ien_r[`UBIRQ_BIT_TX_DMA]) |-> !o_tx_dma_req)
        else $error("tx dma without enable");
    a_rx_dma_gate: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        !$past(ien_r[`UBIRQ_BIT_RX_DMA]) |-> !o_rx_dma_req)
        else $error("rx dma without enable");
    a_rx_load_irq: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        i_rx_load && ien_r[0] && !(i_wr && sel_ien) |=> ##1 o_irq)
        else $error("rx load no irq");
    a_modem_irq: assert property (@(posedge i_mclk)
        disable iff (!i_resetn)
        p_mdm && !p_line && !p_rx && !p_tx |-> iir_val[2:0] == 3'h0)
        else $error("modem code wrong");
    a_tx_data_load: assert property (@(posedge i_mclk)
        disable iff (!i_resetn) tx_wr |=> tx_r == $past(i_wdata[7:0]))
        else $error("tx byte not loaded");

endmodule

// ==== test/ubirq_partner.sv ====
// Behavioural receiver and transmit shifter facing the buffer block
`timescale 1ns/1ps
module ubirq_partner (
    input wire logic i_mclk,
    input wire logic i_send,
    input wire logic [7:0] i_byte,
    input wire logic i_slow,
    input wire logic i_tx_full,
    output logic o_rx_load,
    output logic [7:0] o_rx_byte,
    output logic o_tx_take
);
    logic [2:0] wait_r;
    // ==========
    // Receive side
    // Byte lines toggle outside a load so a stale byte is never trusted
    always @(posedge i_mclk) begin
        o_rx_load <= i_send;
        o_rx_byte <= i_send ? i_byte : ~o_rx_byte;
    end
    // ==========
    // Transmit side
    // Slow mode leaves the holding byte pending for several cycles
    always @(posedge i_mclk) begin
        wait_r <= (i_tx_full && !o_tx_take) ? wait_r + 3'h1 : 3'h0;
        o_tx_take <= i_tx_full && !o_tx_take && (!i_slow || wait_r == 3'h5);
    end
endmodule

// ==== test/ubirq_top_bench.sv ====
// Self-checking bench for the UART buffer and interrupt registers
`timescale 1ns/1ps
`include "ubirq_map.svh"
module ubirq_top_bench;
    localparam logic [31:0] k0 = 32'h0000_0000;
    localparam logic [31:0] k1 = 32'h0000_0001;
    logic i_mclk, i_resetn, i_wr, i_rd, rd_d, snd, slow;
    logic [31:0] i_addr, i_wdata, o_rdata;
    logic i_rx_load, i_tx_take, i_line_err, i_line_rd, i_modem_stat;
    logic [7:0] i_rx_byte, o_tx_byte, snd_byte, b;
    logic o_tx_full, o_irq, o_tx_dma_req, o_rx_dma_req, o_evt_irq;
    logic [15:0] seed;
    logic [31:0] exp_q[$];
    int n_errors, num_checks;
    ubirq_top i_ubirq_top (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_rx_load(i_rx_load), .i_rx_byte(i_rx_byte),
        .i_tx_take(i_tx_take), .i_line_err(i_line_err),
        .i_line_rd(i_line_rd), .i_modem_stat(i_modem_stat),
        .o_tx_byte(o_tx_byte), .o_tx_full(o_tx_full), .o_irq(o_irq),
        .o_tx_dma_req(o_tx_dma_req), .o_rx_dma_req(o_rx_dma_req),
        .o_evt_irq(o_evt_irq));
    ubirq_partner i_ubirq_partner (.i_mclk(i_mclk), .i_send(snd),
        .i_byte(snd_byte), .i_slow(slow), .i_tx_full(o_tx_full),
        .o_rx_load(i_rx_load), .o_rx_byte(i_rx_byte), .o_tx_take(i_tx_take));
    // ==========
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, e);
        end
    endtask
    // A read notes its expected word; the watcher compares it later
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= w ? d : k0;
        if (!w) exp_q.push_back(d);
    endtask
    task automatic nap(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            {i_wr, i_rd, snd, i_line_err, i_line_rd} <= 5'h00;
        end
        @(negedge i_mclk);
    endtask
    task automatic send(input logic [7:0] v);
        @(posedge i_mclk);
        snd <= 1'b1;
        snd_byte <= v;
        nap(4);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========
    // Watcher, clock and watchdog
    always @(posedge i_mclk) begin
        if (rd_d) chk(o_rdata, exp_q.pop_front());
        rd_d <= i_rd;
    end
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        #(40 * 4000);
        n_errors++;
        print_verdict();
    end
    // ==========
    // Main sequence
    initial begin
        {i_resetn, i_wr, i_rd, snd, i_line_err, i_line_rd} = 6'h00;
        {i_modem_stat, i_addr, i_wdata, snd_byte} = 73'h0;
        slow = 1'b1;
        seed = 16'h81e6;
        n_errors = 0;
        num_checks = 0;
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        bus(0, `UBIRQ_OFF_DATA, k0);
        bus(0, `UBIRQ_OFF_IEN, k0);
        bus(0, `UBIRQ_OFF_IIR, k1);
        bus(0, `UBIRQ_OFF_EVT, k0);
        bus(1, `UBIRQ_OFF_IEN, 32'hffff_ffff);
        bus(0, `UBIRQ_OFF_IEN, 32'h0000_003f);
        nap(2);
        chk(32'(o_irq), k1);
        chk(32'(o_tx_dma_req), k1);
        chk(32'(o_rx_dma_req), k0);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0002);
        nap(1);
        bus(0, `UBIRQ_OFF_IIR, k1);
        nap(2);
        chk(32'(o_irq), k0);
        seed = lfsr(seed);
        bus(1, `UBIRQ_OFF_DATA, {24'h00_0000, seed[7:0]});
        nap(2);
        chk(32'(o_tx_byte), 32'(seed[7:0]));
        chk(32'(o_tx_full), k1);
        chk(32'(o_tx_dma_req), k0);
        chk(32'(o_irq), k0);
        nap(10);
        chk(32'(o_irq), k1);
        slow = 1'b0;
        bus(1, `UBIRQ_OFF_DATA, {24'h00_0000, ~seed[7:0]});
        nap(3);
        chk(32'(o_tx_full), k0);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0002);
        nap(2);
        seed = lfsr(seed);
        b = seed[7:0];
        send(b);
        chk(32'(o_rx_dma_req), k1);
        chk(32'(o_irq), k1);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0004);
        bus(0, `UBIRQ_OFF_DATA, 32'(b));
        nap(1);
        bus(0, `UBIRQ_OFF_IIR, k1);
        nap(1);
        @(posedge i_mclk);
        i_modem_stat <= 1'b1;
        i_line_err <= 1'b1;
        seed = lfsr(seed);
        b = seed[7:0];
        send(b);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0006);
        nap(1);
        @(posedge i_mclk);
        i_line_rd <= 1'b1;
        nap(2);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0004);
        bus(0, `UBIRQ_OFF_DATA, 32'(b));
        nap(1);
        bus(0, `UBIRQ_OFF_IIR, k0);
        nap(2);
        chk(32'(o_irq), k1);
        @(posedge i_mclk);
        i_modem_stat <= 1'b0;
        nap(2);
        bus(0, `UBIRQ_OFF_IIR, k1);
        nap(2);
        chk(32'(o_irq), k0);
        // Receive-full enabled late, while the buffer already holds a byte
        bus(1, `UBIRQ_OFF_IEN, k0);
        nap(1);
        send(b);
        chk(32'(o_irq), k0);
        chk(32'({o_tx_dma_req, o_rx_dma_req}), k0);
        bus(1, `UBIRQ_OFF_IEN, k1);
        nap(2);
        chk(32'(o_irq), k1);
        // Sticky event status with its mask
        bus(1, `UBIRQ_OFF_ISTAT, 32'h0000_000f);
        bus(1, `UBIRQ_OFF_IMASK, k1);
        nap(1);
        send(b);
        chk(32'(o_evt_irq), k1);
        bus(0, `UBIRQ_OFF_ISTAT, k1);
        bus(1, `UBIRQ_OFF_IMASK, k0);
        nap(2);
        chk(32'(o_evt_irq), k0);
        bus(1, `UBIRQ_OFF_IMASK, k1);
        bus(1, `UBIRQ_OFF_ISTAT, k1);
        nap(2);
        chk(32'(o_evt_irq), k0);
        // Transmit empty enabled late, while the holding is already empty
        bus(1, `UBIRQ_OFF_IEN, 32'h0000_0002);
        nap(2);
        chk(32'(o_irq), k1);
        bus(0, `UBIRQ_OFF_IIR, 32'h0000_0002);
        nap(2);
        chk(32'(o_irq), k0);
        print_verdict();
    end
endmodule
